// ### hdl/ats_consts.svh
// constants for the arm/trigger sequencer: offsets, fields, resets
// assumes inclusion by the design and by its bench
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH

`define ATS_NCH        2
`define ATS_CNT_MAX    17'h186a0
`define ATS_CNT_INF    17'h00000
`define ATS_CNT_RST    17'h00001
`define ATS_CNT_ONE    17'h00001
`define ATS_DLY_RST    32'h00000000
`define ATS_DLY_ONE    32'h00000001
`define ATS_DST_RST    11'h000
`define ATS_OEN_RST    6'h00

// address fields
`define ATS_A_GLOBAL   7
`define ATS_A_CHAN     6
`define ATS_A_IDX_HI   5
`define ATS_A_IDX_LO   2

// per-channel register indices
`define ATS_R_CTRL     4'h0
`define ATS_R_ARM_SRC  4'h1
`define ATS_R_TRG_SRC  4'h2
`define ATS_R_ARM_CNT  4'h3
`define ATS_R_TRG_CNT  4'h4
`define ATS_R_ARM_DLY  4'h5
`define ATS_R_TRG_DLY  4'h6
`define ATS_R_PERIOD   4'h7
`define ATS_R_OUT_EN   4'h8
`define ATS_R_OUT_DST  4'h9
`define ATS_R_STATUS   4'ha
`define ATS_R_ARM_NOW  4'hb
`define ATS_R_TRG_NOW  4'hc
// global register index
`define ATS_R_MODE     4'h0

`define ATS_CTRL_INIT  0
`define ATS_CTRL_ABORT 1
`define ATS_MODE_AUTO  0

// trigger output event bits
`define ATS_EV_ARM_B   0
`define ATS_EV_ARM_A   1
`define ATS_EV_TRG_B   2
`define ATS_EV_TRG_A   3
`define ATS_EV_ACT_B   4
`define ATS_EV_ACT_A   5

// trigger output destination bits
`define ATS_D_INT_LO   0
`define ATS_D_INT_HI   1
`define ATS_D_DIO_LO   2
`define ATS_D_DIO_HI   8
`define ATS_D_LAN      9
`define ATS_D_JACK     10

`endif

// ### hdl/ats_pkg.sv
// types of the arm/trigger sequencer
// assumes nothing beyond a SystemVerilog compiler
package ats_pkg;

  typedef logic [7:0]  ats_addr_t;
  typedef logic [31:0] ats_word_t;

  typedef enum logic [2:0] {
    ATS_IDLE      = 3'b000,
    ATS_ARM_WAIT  = 3'b001,
    ATS_ARM_DLY   = 3'b010,
    ATS_TRG_WAIT  = 3'b011,
    ATS_TRG_DLY   = 3'b100,
    ATS_ACT       = 3'b101
  } ats_state_t;

  // code is the bit index into the source vector
  typedef enum logic [3:0] {
    ATS_SRC_AUTO  = 4'h0,
    ATS_SRC_BUS   = 4'h1,
    ATS_SRC_TIMER = 4'h2,
    ATS_SRC_LINE_ONE = 4'h3,
    ATS_SRC_LINE_TWO = 4'h4,
    ATS_SRC_DIO1  = 4'h5,
    ATS_SRC_DIO7  = 4'hb,
    ATS_SRC_LAN   = 4'hc,
    ATS_SRC_JACK  = 4'hd
  } ats_src_t;

endpackage : ats_pkg

// ### hdl/ats_top.sv
// two independent arm/trigger sequencers (0 transient, 1 acquire)
// assumes all inputs but NRST_I synchronous to CLK_I; event inputs are levels
// sampled each cycle, action done is a one-cycle pulse
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ats_consts.svh"

module ats_top (
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  input  wire ats_pkg::ats_addr_t ADDR_I,
  input  wire ats_pkg::ats_word_t WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output ats_pkg::ats_word_t     RDATA_O,
  input  wire logic              BUS_TRIG_I,
  input  wire logic [1:0]        INT_LINE_I,
  input  wire logic [6:0]        DIO_I,
  input  wire logic              LAN_TRIG_I,
  input  wire logic              TRIG_IN_I,
  input  wire logic [1:0]        ACT_DONE_I,
  output logic      [1:0]        ACT_START_O,
  output logic      [1:0]        BUSY_O,
  output logic      [1:0]        INT_LINE_O,
  output logic      [6:0]        DIO_O,
  output logic                   LAN_TRIG_O,
  output logic                   TRIG_OUT_O
);
  import ats_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // register decode
  // ****************************************
  logic [3:0]  idx;
  logic        ch_wr;
  logic        ch_sel;
  logic [16:0] wr_cnt;
  logic        auto_mode;

  assign idx    = ADDR_I[`ATS_A_IDX_HI:`ATS_A_IDX_LO];
  assign ch_wr  = WR_I && !ADDR_I[`ATS_A_GLOBAL];
  assign ch_sel = ADDR_I[`ATS_A_CHAN];
  // zero means infinite; values past the top clamp to it
  assign wr_cnt = (WDATA_I > {15'h0000, `ATS_CNT_MAX}) ? `ATS_CNT_MAX
                                                      : WDATA_I[16:0];

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      auto_mode <= 1'b0;
    end else if (WR_I && ADDR_I[`ATS_A_GLOBAL] && idx == `ATS_R_MODE) begin
      auto_mode <= WDATA_I[`ATS_MODE_AUTO];
    end
  end

  // ****************************************
  // per-sequencer state
  // ****************************************
  ats_state_t  st       [`ATS_NCH];
  ats_src_t    arm_src  [`ATS_NCH];
  ats_src_t    trg_src  [`ATS_NCH];
  logic [16:0] arm_lim  [`ATS_NCH];
  logic [16:0] trg_lim  [`ATS_NCH];
  logic [16:0] arm_cnt  [`ATS_NCH];
  logic [16:0] trg_cnt  [`ATS_NCH];
  logic [31:0] arm_dly  [`ATS_NCH];
  logic [31:0] trg_dly  [`ATS_NCH];
  logic [31:0] period   [`ATS_NCH];
  logic [31:0] dcnt     [`ATS_NCH];
  logic [31:0] tmr      [`ATS_NCH];
  logic [5:0]  out_en   [`ATS_NCH];
  logic [10:0] out_dst  [`ATS_NCH];
  logic [5:0]  evt      [`ATS_NCH];
  logic [10:0] fire     [`ATS_NCH];

  genvar g;
  generate
    for (g = 0; g < `ATS_NCH; g++) begin : g_ch
      logic        sel;
      logic        init_req;
      logic        abort_req;
      logic        init_ok;
      logic        tmr_hit;
      logic [15:0] src_vec;
      logic        arm_ev;
      logic        trg_ev;
      logic        trg_last;
      logic        arm_last;
      logic        done;

      assign sel       = ch_wr && (ch_sel == g[0]);
      assign init_req  = sel && idx == `ATS_R_CTRL
                         && WDATA_I[`ATS_CTRL_INIT];
      assign abort_req = sel && idx == `ATS_R_CTRL
                         && WDATA_I[`ATS_CTRL_ABORT];
      // auto mode keeps acquire restarting and locks transient out
      assign init_ok   = (g == 1) ? (init_req || auto_mode)
                                  : (init_req && !auto_mode);
      assign tmr_hit   = (period[g] != `ATS_DLY_RST) && (tmr[g] == 32'h0);
      // auto source resolves to an immediate event
      assign src_vec   = {2'b00, TRIG_IN_I, LAN_TRIG_I, DIO_I, INT_LINE_I,
                          tmr_hit, BUS_TRIG_I, 1'b1};
      assign arm_ev    = src_vec[arm_src[g]];
      assign trg_ev    = src_vec[trg_src[g]];
      assign done      = ACT_DONE_I[g];
      assign trg_last  = trg_lim[g] != `ATS_CNT_INF
                         && (trg_cnt[g] + `ATS_CNT_ONE) == trg_lim[g];
      assign arm_last  = arm_lim[g] != `ATS_CNT_INF
                         && (arm_cnt[g] + `ATS_CNT_ONE) == arm_lim[g];

      // ****************************************
      // configuration registers
      // ****************************************
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          arm_src[g] <= ATS_SRC_AUTO;
          trg_src[g] <= ATS_SRC_AUTO;
          arm_lim[g] <= `ATS_CNT_RST;
          trg_lim[g] <= `ATS_CNT_RST;
          arm_dly[g] <= `ATS_DLY_RST;
          trg_dly[g] <= `ATS_DLY_RST;
          period[g]  <= `ATS_DLY_RST;
          out_en[g]  <= `ATS_OEN_RST;
          out_dst[g] <= `ATS_DST_RST;
        end else if (sel) begin
          unique case (idx)
            `ATS_R_ARM_SRC: arm_src[g] <= ats_src_t'(WDATA_I[3:0]);
            `ATS_R_TRG_SRC: trg_src[g] <= ats_src_t'(WDATA_I[3:0]);
            `ATS_R_ARM_CNT: arm_lim[g] <= wr_cnt;
            `ATS_R_TRG_CNT: trg_lim[g] <= wr_cnt;
            `ATS_R_ARM_DLY: arm_dly[g] <= WDATA_I;
            `ATS_R_TRG_DLY: trg_dly[g] <= WDATA_I;
            `ATS_R_PERIOD:  period[g]  <= WDATA_I;
            `ATS_R_OUT_EN:  out_en[g]  <= WDATA_I[5:0];
            `ATS_R_OUT_DST: out_dst[g] <= WDATA_I[10:0];
            default: ;
          endcase
        end
      end

      // ****************************************
      // period timer
      // ****************************************
      // restarts on arm-wait entry and on trigger-wait entry from the arm delay, so the first event there is a full period
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          tmr[g] <= `ATS_DLY_RST;
        end else if (period[g] == `ATS_DLY_RST) begin
          tmr[g] <= `ATS_DLY_RST;
        end else if (evt[g][`ATS_EV_ARM_B] || evt[g][`ATS_EV_TRG_B]
                     || tmr[g] == 32'h0) begin
          tmr[g] <= period[g] - `ATS_DLY_ONE;
        end else begin
          tmr[g] <= tmr[g] - `ATS_DLY_ONE;
        end
      end

      // ****************************************
      // sequencer
      // ****************************************
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          st[g]          <= ATS_IDLE;
          arm_cnt[g]     <= `ATS_CNT_INF;
          trg_cnt[g]     <= `ATS_CNT_INF;
          dcnt[g]        <= `ATS_DLY_RST;
          ACT_START_O[g] <= 1'b0;
          evt[g]         <= `ATS_OEN_RST;
        end else begin
          ACT_START_O[g] <= 1'b0;
          evt[g]         <= `ATS_OEN_RST;
          if (abort_req || (g == 0 && auto_mode)) begin
            st[g] <= ATS_IDLE;
          end else begin
            unique case (st[g])
              ATS_IDLE: if (init_ok) begin
                st[g]                  <= ATS_ARM_WAIT;
                arm_cnt[g]             <= `ATS_CNT_INF;
                evt[g][`ATS_EV_ARM_B]  <= 1'b1;
              end
              ATS_ARM_WAIT: if (arm_ev) begin
                st[g]   <= ATS_ARM_DLY;
                dcnt[g] <= arm_dly[g];
              end
              ATS_ARM_DLY: if (dcnt[g] == 32'h0) begin
                st[g]                  <= ATS_TRG_WAIT;
                trg_cnt[g]             <= `ATS_CNT_INF;
                evt[g][`ATS_EV_TRG_B]  <= 1'b1;
              end else begin
                dcnt[g] <= dcnt[g] - `ATS_DLY_ONE;
              end
              ATS_TRG_WAIT: if (trg_ev) begin
                st[g]   <= ATS_TRG_DLY;
                dcnt[g] <= trg_dly[g];
              end
              ATS_TRG_DLY: if (dcnt[g] == 32'h0) begin
                st[g]                  <= ATS_ACT;
                ACT_START_O[g]         <= 1'b1;
                evt[g][`ATS_EV_ACT_B]  <= 1'b1;
              end else begin
                dcnt[g] <= dcnt[g] - `ATS_DLY_ONE;
              end
              ATS_ACT: if (done) begin
                evt[g][`ATS_EV_ACT_A] <= 1'b1;
                trg_cnt[g] <= trg_cnt[g] + `ATS_CNT_ONE;
                if (!trg_last) begin
                  st[g] <= ATS_TRG_WAIT;
                end else begin
                  evt[g][`ATS_EV_TRG_A] <= 1'b1;
                  evt[g][`ATS_EV_ARM_A] <= 1'b1;
                  arm_cnt[g] <= arm_cnt[g] + `ATS_CNT_ONE;
                  if (arm_last) begin
                    st[g] <= ATS_IDLE;
                  end else begin
                    st[g]                 <= ATS_ARM_WAIT;
                    evt[g][`ATS_EV_ARM_B] <= 1'b1;
                  end
                end
              end
              default: st[g] <= ATS_IDLE;
            endcase
          end
        end
      end

      assign fire[g] = (|(evt[g] & out_en[g])) ? out_dst[g] : `ATS_DST_RST;
      assign BUSY_O[g] = st[g] != ATS_IDLE;

      // ****************************************
      // checks
      // ****************************************
      sequence s_trg_fire;
        st[g] == ATS_TRG_DLY && dcnt[g] == 32'h0 && !abort_req
          && !(g == 0 && auto_mode);
      endsequence

      sequence s_act_end;
        st[g] == ATS_ACT && done && !abort_req && !(g == 0 && auto_mode);
      endsequence

      AST_INIT_ARM: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        st[g] == ATS_IDLE && init_ok && !abort_req
          && !(g == 0 && auto_mode)
        |=> st[g] == ATS_ARM_WAIT && arm_cnt[g] == `ATS_CNT_INF)
        else $error("initiate did not enter arm layer");

      AST_ARM_HOLD: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        st[g] == ATS_ARM_WAIT && !arm_ev && !abort_req
          && !(g == 0 && auto_mode)
        |=> st[g] == ATS_ARM_WAIT)
        else $error("arm layer left without event");

      AST_ARM_DELAY: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        st[g] == ATS_ARM_WAIT && arm_ev && arm_dly[g] == `ATS_DLY_ONE
          && !abort_req && !(g == 0 && auto_mode)
        |=> st[g] == ATS_ARM_DLY ##1 st[g] == ATS_ARM_DLY
          ##1 st[g] == ATS_TRG_WAIT)
        else $error("arm delay of one cycle not kept");

      AST_TRG_HOLD: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        st[g] == ATS_TRG_WAIT && !trg_ev && !abort_req
          && !(g == 0 && auto_mode)
        |=> st[g] == ATS_TRG_WAIT)
        else $error("trigger layer left without event");

      AST_ACT_START: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        s_trg_fire |=> ACT_START_O[g] && st[g] == ATS_ACT
          ##1 !ACT_START_O[g])
        else $error("action start not one pulse after delay");

      AST_TRG_LOOP: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        s_act_end and (##0 !trg_last)
        |=> st[g] == ATS_TRG_WAIT
          && trg_cnt[g] == $past(trg_cnt[g]) + `ATS_CNT_ONE)
        else $error("trigger loop step wrong");

      AST_ARM_LOOP: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        s_act_end and (##0 trg_last && !arm_last)
        |=> st[g] == ATS_ARM_WAIT
          && arm_cnt[g] == $past(arm_cnt[g]) + `ATS_CNT_ONE)
        else $error("arm loop step wrong");

      AST_ARM_END: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        s_act_end and (##0 trg_last && arm_last)
        |=> st[g] == ATS_IDLE && !BUSY_O[g])
        else $error("last arm pass did not return to idle");

      AST_TRG_ENTRY: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        st[g] == ATS_ARM_DLY ##1 st[g] == ATS_TRG_WAIT
        |-> trg_cnt[g] == `ATS_CNT_INF)
        else $error("trigger counter not cleared on entry");

      // jack destination stands for every enabled event of this copy
      AST_OUT_PULSE: assert property (@(posedge CLK_I)
        disable iff (!rst_n)
        |(evt[g] & out_en[g]) && out_dst[g][`ATS_D_JACK]
        |=> TRIG_OUT_O)
        else $error("trigger output pulse missing");

      if (g == 0) begin : g_tr_chk
        AST_AUTO_LOCK: assert property (@(posedge CLK_I)
          disable iff (!rst_n)
          auto_mode |=> st[g] == ATS_IDLE && !ACT_START_O[g])
          else $error("transient ran in auto mode");
      end
    end
  endgenerate

  // ****************************************
  // trigger outputs
  // ****************************************
  // both sequencers share every destination, so pulses merge by OR
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      INT_LINE_O <= 2'b00;
      DIO_O      <= 7'h00;
      LAN_TRIG_O <= 1'b0;
      TRIG_OUT_O <= 1'b0;
    end else begin
      INT_LINE_O <= fire[0][`ATS_D_INT_HI:`ATS_D_INT_LO]
                  | fire[1][`ATS_D_INT_HI:`ATS_D_INT_LO];
      DIO_O      <= fire[0][`ATS_D_DIO_HI:`ATS_D_DIO_LO]
                  | fire[1][`ATS_D_DIO_HI:`ATS_D_DIO_LO];
      LAN_TRIG_O <= fire[0][`ATS_D_LAN] | fire[1][`ATS_D_LAN];
      TRIG_OUT_O <= fire[0][`ATS_D_JACK] | fire[1][`ATS_D_JACK];
    end
  end

  // ****************************************
  // read back
  // ****************************************
  logic rc;
  assign rc = ch_sel;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 32'h0;
    end else if (!RD_I) begin
      RDATA_O <= 32'h0;
    end else if (ADDR_I[`ATS_A_GLOBAL]) begin
      RDATA_O <= (idx == `ATS_R_MODE) ? {31'h0, auto_mode} : 32'h0;
    end else begin
      unique case (idx)
        `ATS_R_ARM_SRC: RDATA_O <= {28'h0, arm_src[rc]};
        `ATS_R_TRG_SRC: RDATA_O <= {28'h0, trg_src[rc]};
        `ATS_R_ARM_CNT: RDATA_O <= {15'h0, arm_lim[rc]};
        `ATS_R_TRG_CNT: RDATA_O <= {15'h0, trg_lim[rc]};
        `ATS_R_ARM_DLY: RDATA_O <= arm_dly[rc];
        `ATS_R_TRG_DLY: RDATA_O <= trg_dly[rc];
        `ATS_R_PERIOD:  RDATA_O <= period[rc];
        `ATS_R_OUT_EN:  RDATA_O <= {26'h0, out_en[rc]};
        `ATS_R_OUT_DST: RDATA_O <= {21'h0, out_dst[rc]};
        `ATS_R_STATUS:  RDATA_O <= {29'h0, st[rc]};
        `ATS_R_ARM_NOW: RDATA_O <= {15'h0, arm_cnt[rc]};
        `ATS_R_TRG_NOW: RDATA_O <= {15'h0, trg_cnt[rc]};
        default:        RDATA_O <= 32'h0;
      endcase
    end
  end

endmodule // ats_top

// ### testbench/ats_act_model.sv
// far-side model: executors of the transient and acquire actions
// assumes start pulses from the sequencer; answers with a done pulse
`timescale 1ns/1ps

module ats_act_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] start_i,
  input  wire logic [1:0] slow_i,
  output logic      [1:0] done_o
);
  // ************************************************************
  // one action per start, done after a short or a long run
  // ************************************************************
  int cnt [2];

  // slow runs keep the sequencer parked in its action state longer
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 2'h0;
      cnt    <= '{0, 0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        done_o[c] <= (cnt[c] == 1);
        if (start_i[c])
          cnt[c] <= slow_i[c] ? 6 : 1;
        else if (cnt[c] > 0)
          cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule // ats_act_model

// ### testbench/ats_top_test.sv
// self-checking bench for the two arm/trigger sequencers
// assumes ats_top, ats_pkg, ats_consts.svh and the action model
`timescale 1ns/1ps
`include "ats_consts.svh"

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end

module ats_top_test;
  import ats_pkg::*;
  logic       CLK_I = 1'b0, NRST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
  ats_addr_t  ADDR_I = 8'h00;
  ats_word_t  WDATA_I = 32'h0, RDATA_O;
  logic [13:0] evt = 14'h0;
  logic [1:0] ACT_DONE_I, ACT_START_O, BUSY_O, INT_LINE_O, slow = 2'h0;
  logic [6:0] DIO_O;
  logic       LAN_TRIG_O, TRIG_OUT_O;
  int         fails = 0, comparisons = 0, starts [2] = '{0, 0};
  int         oall = 0, opulse = 0, n, s0;
  int tab [12][4] = '{'{0,1,0,1}, '{1,3,1,2}, '{0,4,2,3}, '{1,5,3,4},
    '{0,6,0,1}, '{1,7,1,2}, '{0,8,2,3}, '{1,9,3,4}, '{0,10,0,1},
    '{1,11,1,2}, '{0,12,2,3}, '{1,13,3,4}};

  always #12.5 CLK_I = ~CLK_I;

  ats_top i_ats_top (.CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .BUS_TRIG_I(evt[1]), .INT_LINE_I(evt[4:3]), .DIO_I(evt[11:5]),
    .LAN_TRIG_I(evt[12]), .TRIG_IN_I(evt[13]), .ACT_DONE_I(ACT_DONE_I),
    .ACT_START_O(ACT_START_O), .BUSY_O(BUSY_O), .INT_LINE_O(INT_LINE_O),
    .DIO_O(DIO_O), .LAN_TRIG_O(LAN_TRIG_O), .TRIG_OUT_O(TRIG_OUT_O));

  ats_act_model i_ats_act_model (.clk_i(CLK_I), .rst_n_i(NRST_I),
    .start_i(ACT_START_O), .slow_i(slow), .done_o(ACT_DONE_I));

  // ************************************************************
  // monitors and bus tasks
  // ************************************************************
  always @(posedge CLK_I) begin
    for (int c = 0; c < 2; c++)
      if (ACT_START_O[c] === 1'b1) starts[c]++;
    if ({TRIG_OUT_O, LAN_TRIG_O, DIO_O, INT_LINE_O} === 11'h7ff) oall++;
    if ({TRIG_OUT_O, LAN_TRIG_O, DIO_O, INT_LINE_O} !== 11'h0) opulse++;
  end

  function automatic ats_addr_t ra(input logic ch, input logic [3:0] i);
    return {1'b0, ch, i, 2'b00};
  endfunction

  task automatic close_out();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input ats_addr_t a, input ats_word_t v);
    @(posedge CLK_I);
    WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= v;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic chk_rd(input ats_addr_t a, input ats_word_t e);
    @(posedge CLK_I);
    RD_I <= 1'b1; ADDR_I <= a;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 `CHK(RDATA_O, e)
  endtask

  task automatic cfg(input logic ch, input logic [3:0] as,
                     input logic [3:0] ts,
                     input ats_word_t ac, input ats_word_t tc,
                     input ats_word_t ad, input ats_word_t td);
    wr(ra(ch, `ATS_R_ARM_SRC), {28'h0, as});
    wr(ra(ch, `ATS_R_TRG_SRC), {28'h0, ts});
    wr(ra(ch, `ATS_R_ARM_CNT), ac);
    wr(ra(ch, `ATS_R_TRG_CNT), tc);
    wr(ra(ch, `ATS_R_ARM_DLY), ad);
    wr(ra(ch, `ATS_R_TRG_DLY), td);
  endtask

  task automatic wait_idle(input int ch);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge CLK_I);
      #1;
      if (BUSY_O[ch] === 1'b0) break;
    end
    if (i == 400) begin
      fails++;
      $display("mismatch at %0t: sequencer never went idle", $time);
      close_out();
    end
  endtask

  // one-cycle event, then edges counted until the action starts
  task automatic fire(input int src, input int ch, output int k);
    @(posedge CLK_I);
    evt[src] <= 1'b1;
    @(posedge CLK_I);
    evt[src] <= 1'b0;
    for (k = 1; k <= 64; k++) begin
      @(posedge CLK_I);
      #1;
      if (ACT_START_O[ch] === 1'b1) break;
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge CLK_I);
    `CHK({ACT_START_O, BUSY_O, INT_LINE_O, DIO_O}, 13'h0)
    `CHK({RDATA_O, LAN_TRIG_O, TRIG_OUT_O}, 34'h0)
    repeat (4) @(posedge CLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk_rd(ra(0, `ATS_R_ARM_CNT), 32'h1);
    chk_rd(ra(1, `ATS_R_TRG_CNT), 32'h1);
    chk_rd(ra(0, `ATS_R_ARM_DLY), 32'h0);
    chk_rd(ra(1, `ATS_R_PERIOD), 32'h0);
    chk_rd(ra(0, `ATS_R_TRG_SRC), 32'h0);
    chk_rd(ra(1, `ATS_R_STATUS), 32'h0);
    wr(ra(0, 4'hd), 32'h5);
    chk_rd(ra(0, 4'hd), 32'h0);
    // table rows: channel, trigger source, trigger delay, start latency
    for (int i = 0; i < 12; i++) begin
      cfg(tab[i][0][0], 4'h0, tab[i][1][3:0], 32'h1, 32'h1, 32'h0, tab[i][2]);
      s0 = starts[tab[i][0]];
      wr(ra(tab[i][0][0], `ATS_R_CTRL), 32'h1);
      repeat (4) @(posedge CLK_I);
      chk_rd(ra(tab[i][0][0], `ATS_R_STATUS), 32'h3);
      `CHK(BUSY_O[1 - tab[i][0]], 1'b0)
      fire(tab[i][1], tab[i][0], n);
      `CHK(n, tab[i][3])
      @(posedge CLK_I);
      #1 `CHK(ACT_START_O[tab[i][0]], 1'b0)
      wait_idle(tab[i][0]);
      `CHK(starts[tab[i][0]], s0 + 1)
    end
    // arm delay of 3 before the trigger layer
    cfg(0, 4'hd, 4'h0, 32'h1, 32'h1, 32'h3, 32'h0);
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    fire(13, 0, n);
    `CHK(n, 6)
    wait_idle(0);
    // arm delay of 1: two cycles in the delay state
    cfg(0, 4'hd, 4'h0, 32'h1, 32'h1, 32'h1, 32'h0);
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    fire(13, 0, n);
    `CHK(n, 4)
    wait_idle(0);
    // nested loops with slow actions: 2 arm passes of 3 actions
    cfg(1, 4'h0, 4'h0, 32'h2, 32'h3, 32'h0, 32'h0);
    slow <= 2'h2;
    s0 = starts[1];
    wr(ra(1, `ATS_R_CTRL), 32'h1);
    wr(ra(1, `ATS_R_CTRL), 32'h1);
    wait_idle(1);
    `CHK(starts[1], s0 + 6)
    chk_rd(ra(1, `ATS_R_ARM_NOW), 32'h2);
    chk_rd(ra(1, `ATS_R_TRG_NOW), 32'h3);
    slow <= 2'h0;
    wr(ra(1, `ATS_R_TRG_CNT), 32'h30d40);
    chk_rd(ra(1, `ATS_R_TRG_CNT), 32'h186a0);
    // infinite count runs until aborted
    cfg(0, 4'h0, 4'h0, 32'h1, 32'h0, 32'h0, 32'h0);
    s0 = starts[0];
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    repeat (80) @(posedge CLK_I);
    #1 `CHK(starts[0] > s0 + 3, 1'b1)
    `CHK(BUSY_O[0], 1'b1)
    wr(ra(0, `ATS_R_CTRL), 32'h2);
    wait_idle(0);
    // timer: off at period 0, two events at period 5
    cfg(0, 4'h0, 4'h2, 32'h1, 32'h2, 32'h0, 32'h0);
    s0 = starts[0];
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    repeat (40) @(posedge CLK_I);
    `CHK(starts[0], s0)
    wr(ra(0, `ATS_R_CTRL), 32'h2);
    wr(ra(0, `ATS_R_PERIOD), 32'h5);
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    wait_idle(0);
    `CHK(starts[0], s0 + 2)
    // trigger output one cycle after each action start, on every destination
    cfg(1, 4'h0, 4'h0, 32'h1, 32'h3, 32'h0, 32'h0);
    wr(ra(1, `ATS_R_OUT_DST), 32'h7ff);
    wr(ra(1, `ATS_R_OUT_EN), 32'h10);
    s0 = oall;
    n = opulse;
    wr(ra(1, `ATS_R_CTRL), 32'h1);
    wait_idle(1);
    repeat (4) @(posedge CLK_I);
    `CHK(oall, s0 + 3)
    `CHK(opulse, n + 3)
    wr(ra(1, `ATS_R_OUT_EN), 32'h0);
    // automatic run: acquire only
    s0 = starts[0];
    n = starts[1];
    wr(8'h80, 32'h1);
    repeat (30) @(posedge CLK_I);
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    repeat (5) @(posedge CLK_I);
    #1 `CHK(BUSY_O, 2'h2)
    `CHK(starts[1] > n, 1'b1)
    `CHK(starts[0], s0)
    wr(8'h80, 32'h0);
    wr(ra(1, `ATS_R_CTRL), 32'h2);
    wait_idle(1);
    // reset in mid-run brings state and registers back
    cfg(0, 4'h0, 4'h0, 32'h1, 32'h0, 32'h0, 32'h0);
    wr(ra(0, `ATS_R_CTRL), 32'h1);
    repeat (10) @(posedge CLK_I);
    NRST_I <= 1'b0;
    repeat (8) @(posedge CLK_I);
    `CHK({ACT_START_O, BUSY_O}, 4'h0)
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk_rd(ra(0, `ATS_R_TRG_CNT), 32'h1);
    chk_rd(ra(0, `ATS_R_STATUS), 32'h0);
    close_out();
  end
endmodule // ats_top_test
